// ==== bench/fdr_host_model.sv ====
// Host controller side: acknowledges each diagnostic request once after a delay set by the bench; hardware requests at once unless held back
module fdr_host_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic diag_irq_req,
  input wire logic hw_irq_req,
  input wire logic hold_hw,
  input wire logic [3:0] ack_dly,
  output logic diag_irq_ack,
  output logic hw_irq_ack
);
  timeunit 1ns;
  timeprecision 100ps;

  // One acknowledge per diagnostic request, then wait for the request to drop
  initial begin
    diag_irq_ack = 1'b0;
    forever begin
      @(posedge core_clk);
      if (nrst && diag_irq_req === 1'b1) begin
        repeat (ack_dly) @(posedge core_clk);
        #1 diag_irq_ack = 1'b1;
        @(posedge core_clk);
        #1 diag_irq_ack = 1'b0;
        while (diag_irq_req === 1'b1) begin
          @(posedge core_clk);
          #1;
        end
      end
    end
  end

  // Hardware acknowledge can be held back so that a second event gets lost
  initial begin
    hw_irq_ack = 1'b0;
    forever begin
      @(posedge core_clk);
      if (nrst && hw_irq_req === 1'b1 && !hold_hw) begin
        #1 hw_irq_ack = 1'b1;
        @(posedge core_clk);
        #1 hw_irq_ack = 1'b0;
      end
    end
  end
endmodule // fdr_host_model

// ==== bench/fdr_reporter_bench.sv ====
module fdr_reporter_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import fdr_pkg::*;

  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [12:0] flt = 13'h0000;
  logic diag_irq_enable = 1'b0;
  logic hw_irq_enable = 1'b0;
  logic hw_event = 1'b0;
  logic count_pulse = 1'b0;
  logic cnt_on = 1'b0;
  logic hold_hw = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [3:0] rec_rd_idx = 4'h0;
  logic diag_irq_ack, hw_irq_ack, group_fault_led, diag_irq_req, hw_irq_req;
  logic [31:0] start_info, count_value, w_exp, exp_cnt;
  fdr_byte_t rec_rd_data, rd_exp;
  logic req_d, rd_pend;
  logic [31:0] exp_q[$];
  int failures = 0;
  int cmp_count = 0;
  int n_seen = 0;

  always #2 core_clk = ~core_clk;

  fdr_reporter dut (.core_clk(core_clk), .nrst(nrst), .pin_aux_missing(flt[0]),
    .pin_enc24_short(flt[1]), .pin_enc52_fault(flt[2]), .pin_sig_a_err(flt[3]),
    .pin_sig_b_err(flt[4]), .pin_sig_n_err(flt[5]), .pin_plug_wrong(flt[6]),
    .prom_test_fail(flt[7]), .ram_test_fail(flt[8]), .wdog_expired(flt[9]),
    .params_missing(flt[10]), .params_faulty(flt[11]), .plug_param_mismatch(flt[12]),
    .diag_irq_enable(diag_irq_enable), .hw_irq_enable(hw_irq_enable), .hw_event(hw_event),
    .hw_irq_ack(hw_irq_ack), .diag_irq_ack(diag_irq_ack), .count_pulse(count_pulse),
    .rec_rd_idx(rec_rd_idx), .group_fault_led(group_fault_led), .diag_irq_req(diag_irq_req),
    .start_info(start_info), .hw_irq_req(hw_irq_req), .rec_rd_data(rec_rd_data),
    .count_value(count_value));

  fdr_host_model host (.core_clk(core_clk), .nrst(nrst), .diag_irq_req(diag_irq_req),
    .hw_irq_req(hw_irq_req), .hold_hw(hold_hw), .ack_dly(ack_dly),
    .diag_irq_ack(diag_irq_ack), .hw_irq_ack(hw_irq_ack));

  // Expected summary record for a set of faults and the lost-interrupt flag
  function automatic logic [31:0] exp_info(input logic [12:0] f, input logic lo);
    logic [7:0] b0;
    logic aux, chan, par;
    aux = f[0] | f[1];
    chan = |f[5:2];
    par = f[6] | f[11] | f[12];
    b0 = {par, f[10], 1'b0, aux, chan, aux | chan | par, f[8] | f[9] | lo, 1'b0};
    b0[0] = |b0[7:1];
    return {1'b0, lo, 2'h0, f[8], 3'h0, 4'h0, f[9], 3'h0, 8'h18, b0};
  endfunction

  function automatic fdr_byte_t exp_byte(input int j, input logic [12:0] f);
    logic [31:0] s;
    s = exp_info(f, 1'b0);
    case (j)
      0, 1, 2, 3: return s[8*j +: 8];
      4: return 8'h76;
      5: return 8'h10;
      6: return 8'h01;
      7: return {7'h00, |f[5:2]};
      8: return {3'h0, f[2], 1'b0, f[5], f[4], f[3]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask
  task automatic cmp_byte(input fdr_byte_t got, input fdr_byte_t exp);
    report({24'h0, got}, {24'h0, exp});
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    report({31'h0, got}, {31'h0, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait until the given number of reports has been seen and closed
  task automatic wait_reports(input int target);
    int k;
    k = 0;
    while ((n_seen < target || diag_irq_req !== 1'b0) && k < 300) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 300) begin
      failures++;
      tally_and_finish();
    end
    #1;
  endtask

  task automatic pulse_hw;
    hw_event = 1'b1;
    step(1);
    hw_event = 1'b0;
  endtask

  // Watcher: each new request is matched against the oldest expected record
  always @(posedge core_clk) begin
    req_d <= diag_irq_req;
    rd_pend <= 1'b0;
    if (rd_pend)
      cmp_byte(rec_rd_data, rd_exp);
    if (nrst && diag_irq_req === 1'b1 && req_d === 1'b0) begin
      n_seen++;
      w_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFF_FFFF;
      cmp_word(start_info, w_exp);
      cmp_flag(group_fault_led, w_exp[7:0] != 8'h00);
      rd_exp <= w_exp[7:0];
      rd_pend <= 1'b1;
    end
  end

  // Random count steps run through all reporting; expected count kept alongside
  always @(posedge core_clk) begin
    if (nrst && count_pulse)
      exp_cnt <= exp_cnt + 32'h1;
    #1 count_pulse = cnt_on & 1'($urandom_range(1, 0));
  end

  // Global guard against a hang
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end

  initial begin
    logic [12:0] f;
    int tgt;
    void'($urandom(32'h8E7E));
    exp_cnt = 32'h0;
    tgt = 0;
    repeat (12) @(posedge core_clk);
    cmp_flag(diag_irq_req, 1'b0);
    cmp_word(start_info, 32'h0);
    #1 nrst = 1'b1;
    step(2);
    cnt_on = 1'b1;
    // Interrupts start disabled: lamp and records follow, no request
    flt[9] = 1'b1;
    step(3);
    cmp_flag(group_fault_led, 1'b1);
    rec_rd_idx = 4'h2;
    step(2);
    cmp_byte(rec_rd_data, 8'h08);
    rec_rd_idx = 4'h0;
    flt[9] = 1'b0;
    step(12);
    cmp_flag(group_fault_led, 1'b0);
    cmp_word(32'(n_seen), 32'h0);
    diag_irq_enable = 1'b1;
    step(2);
    // Every source alone except the program memory test (bit 7): incoming report, record walk (all 16 bytes for channel faults, bytes 0-3 otherwise), outgoing report
    for (int i = 0; i < 13; i++) begin
      if (i != 7) begin
        ack_dly = 4'($urandom_range(7, 0));
        f = 13'h0001 << i;
        exp_q.push_back(exp_info(f, 1'b0));
        flt = f;
        tgt++;
        wait_reports(tgt);
        // Host reads past the summary only when a channel error is reported
        for (int j = 0; j < 16; j++) begin
          if (j < 4 || f[5:2] != 4'h0) begin
            rec_rd_idx = 4'(j);
            step(2);
            cmp_byte(rec_rd_data, exp_byte(j, f));
          end
        end
        rec_rd_idx = 4'h0;
        exp_q.push_back(32'h0000_1800);
        flt = 13'h0000;
        tgt++;
        wait_reports(tgt);
        cmp_flag(group_fault_led, 1'b0);
      end
    end
    // Program memory fault lights the lamp but never interrupts
    flt[7] = 1'b1;
    step(4);
    cmp_flag(group_fault_led, 1'b1);
    step(20);
    cmp_word(32'(n_seen), 32'(tgt));
    flt[7] = 1'b0;
    step(3);
    // Hardware events: ignored while disabled, lost when unacknowledged
    pulse_hw();
    step(3);
    cmp_flag(hw_irq_req, 1'b0);
    hw_irq_enable = 1'b1;
    hold_hw = 1'b1;
    step(2);
    pulse_hw();
    step(1);
    cmp_flag(hw_irq_req, 1'b1);
    exp_q.push_back(32'h4000_1803);
    pulse_hw();
    tgt++;
    wait_reports(tgt);
    exp_q.push_back(32'h0000_1800);
    hold_hw = 1'b0;
    tgt++;
    wait_reports(tgt);
    cmp_flag(hw_irq_req, 1'b0);
    cnt_on = 1'b0;
    step(3);
    cmp_word(count_value, exp_cnt);
    cmp_word(32'(exp_q.size()), 32'h0);
    tally_and_finish();
  end
endmodule // fdr_reporter_bench

// ==== inc/fdr_map.svh ====
`ifndef FDR_MAP_SVH
`define FDR_MAP_SVH

// Record byte offsets; offset 0 is the summary byte 0 register
`define FDR_OFS_SUM_B0 4'h0
`define FDR_OFS_B1 4'h1
`define FDR_OFS_B2 4'h2
`define FDR_OFS_B3 4'h3
`define FDR_OFS_B4 4'h4
`define FDR_OFS_B5 4'h5
`define FDR_OFS_B6 4'h6
`define FDR_OFS_B7 4'h7
`define FDR_OFS_B8 4'h8
`define FDR_REC_LEN 16

// Summary byte 0 fields
`define FDR_B0_ERR_STATE 0
`define FDR_B0_INTERNAL 1
`define FDR_B0_EXTERNAL 2
`define FDR_B0_CHANNEL 3
`define FDR_B0_AUX_FAIL 4
`define FDR_B0_NO_CFG 6
`define FDR_B0_PARAM 7
// Bytes 2, 3, 7 and 8 fields
`define FDR_B2_WDOG 3
`define FDR_B3_RAM 3
`define FDR_B3_HW_LOST 6
`define FDR_B7_CHAN_VEC 0
`define FDR_B8_SIG_A 0
`define FDR_B8_SIG_B 1
`define FDR_B8_SIG_N 2
`define FDR_B8_ENC_SUP 4

// Fixed record contents and reset values
`define FDR_B1_FIXED 8'h18
`define FDR_B4_FIXED 8'h76
`define FDR_B5_FIXED 8'h10
`define FDR_B6_FIXED 8'h01
`define FDR_BYTE_RST 8'h00
`define FDR_INFO_RST 32'h0000_0000
`define FDR_SRC_W 10

`endif

// ==== inc/fdr_pkg.sv ====
package fdr_pkg;
  // Reporting sequence, one-hot
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_latch = 3'b010,
    st_signal = 3'b100
  } fdr_state_t;

  typedef logic [7:0] fdr_byte_t;
endpackage

// ==== rtl/fdr_record.sv ====
// Builds the variable bytes of the diagnostic records from live fault levels
module fdr_record (
  input wire logic aux_fail,
  input wire logic enc52_fault,
  input wire logic no_config,
  input wire logic param_error,
  input wire logic wdog_expired,
  input wire logic ram_fail,
  input wire logic hw_lost,
  input wire logic sig_a_err,
  input wire logic sig_b_err,
  input wire logic sig_n_err,
  output fdr_pkg::fdr_byte_t sum_b0,
  output fdr_pkg::fdr_byte_t rec_b2,
  output fdr_pkg::fdr_byte_t rec_b3,
  output fdr_pkg::fdr_byte_t rec_b7,
  output fdr_pkg::fdr_byte_t rec_b8
);
  import fdr_pkg::*;
  `include "fdr_map.svh"
  logic internal_err;
  logic external_err;
  logic channel_err;

  // Group flags of summary byte 0
  assign internal_err = ram_fail | wdog_expired | hw_lost;
  assign external_err = aux_fail | enc52_fault | sig_a_err | sig_b_err | sig_n_err
                      | param_error;
  assign channel_err = sig_a_err | sig_b_err | sig_n_err | enc52_fault;

  // Unassigned bits, bit 5 among them, stay zero
  always_comb begin
    sum_b0 = `FDR_BYTE_RST;
    sum_b0[`FDR_B0_ERR_STATE] = internal_err | external_err | no_config;
    sum_b0[`FDR_B0_INTERNAL] = internal_err;
    sum_b0[`FDR_B0_EXTERNAL] = external_err;
    sum_b0[`FDR_B0_CHANNEL] = channel_err;
    sum_b0[`FDR_B0_AUX_FAIL] = aux_fail;
    sum_b0[`FDR_B0_NO_CFG] = no_config;
    sum_b0[`FDR_B0_PARAM] = param_error;
    rec_b2 = `FDR_BYTE_RST;
    rec_b2[`FDR_B2_WDOG] = wdog_expired;
    rec_b3 = `FDR_BYTE_RST;
    rec_b3[`FDR_B3_RAM] = ram_fail;
    rec_b3[`FDR_B3_HW_LOST] = hw_lost;
    rec_b7 = `FDR_BYTE_RST;
    rec_b7[`FDR_B7_CHAN_VEC] = channel_err;
    rec_b8 = `FDR_BYTE_RST;
    rec_b8[`FDR_B8_SIG_A] = sig_a_err;
    rec_b8[`FDR_B8_SIG_B] = sig_b_err;
    rec_b8[`FDR_B8_SIG_N] = sig_n_err;
    rec_b8[`FDR_B8_ENC_SUP] = enc52_fault;
  end
endmodule // fdr_record

// ==== rtl/fdr_reporter.sv ====
module fdr_reporter #(
  parameter int CNT_W = 32
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pin_aux_missing,
  input wire logic pin_enc24_short,
  input wire logic pin_enc52_fault,
  input wire logic pin_sig_a_err,
  input wire logic pin_sig_b_err,
  input wire logic pin_sig_n_err,
  input wire logic pin_plug_wrong,
  input wire logic prom_test_fail,
  input wire logic ram_test_fail,
  input wire logic wdog_expired,
  input wire logic params_missing,
  input wire logic params_faulty,
  input wire logic plug_param_mismatch,
  input wire logic diag_irq_enable,
  input wire logic hw_irq_enable,
  input wire logic hw_event,
  input wire logic hw_irq_ack,
  input wire logic diag_irq_ack,
  input wire logic count_pulse,
  input wire logic [3:0] rec_rd_idx,
  output logic group_fault_led,
  output logic diag_irq_req,
  output logic [31:0] start_info,
  output logic hw_irq_req,
  output fdr_pkg::fdr_byte_t rec_rd_data,
  output logic [CNT_W-1:0] count_value
);
  import fdr_pkg::*;
  `include "fdr_map.svh"

  localparam int PIN_W = 7;

  logic [PIN_W-1:0] pins_sync;
  logic aux_fail;
  logic enc52_fault;
  logic sig_a_err;
  logic sig_b_err;
  logic sig_n_err;
  logic plug_wrong;
  logic enc24_short;
  logic param_error;
  logic hw_lost;
  logic fault_any;
  logic diag_en;
  logic hw_en;
  logic [`FDR_SRC_W-1:0] src_now;
  logic [`FDR_SRC_W-1:0] src_prev;
  logic src_changed;
  logic redo;
  fdr_state_t state;
  fdr_state_t next_state;
  fdr_byte_t sum_b0;
  fdr_byte_t rec_b2;
  fdr_byte_t rec_b3;
  fdr_byte_t rec_b7;
  fdr_byte_t rec_b8;
  fdr_byte_t detail [`FDR_REC_LEN];

  // Selects the content of one record byte for a snapshot
  function automatic fdr_byte_t record_byte(input int idx, input fdr_byte_t b0,
                                            input fdr_byte_t b2, input fdr_byte_t b3,
                                            input fdr_byte_t b7, input fdr_byte_t b8);
    fdr_byte_t val;
    case (idx)
      0: val = b0;
      1: val = `FDR_B1_FIXED;
      2: val = b2;
      3: val = b3;
      4: val = `FDR_B4_FIXED;
      5: val = `FDR_B5_FIXED;
      6: val = `FDR_B6_FIXED;
      7: val = b7;
      8: val = b8;
      default: val = `FDR_BYTE_RST;
    endcase
    return val;
  endfunction

  // Field wiring faults come from pins, so they pass the synchroniser
  fdr_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in({pin_plug_wrong, pin_sig_n_err, pin_sig_b_err, pin_sig_a_err,
             pin_enc52_fault, pin_enc24_short, pin_aux_missing}),
    .level_out(pins_sync)
  );

  // External fault levels
  assign enc24_short = pins_sync[1];
  assign aux_fail = pins_sync[0] | enc24_short;
  assign enc52_fault = pins_sync[2];
  assign sig_a_err = pins_sync[3];
  assign sig_b_err = pins_sync[4];
  assign sig_n_err = pins_sync[5];
  assign plug_wrong = pins_sync[6];
  // A wrong plug or a plug that contradicts the parameters counts as a parameter error
  assign param_error = params_faulty | plug_wrong | plug_param_mismatch;

  // Any fault at all, the program memory test included, drives the lamp
  assign fault_any = prom_test_fail | ram_test_fail | wdog_expired | hw_lost
                   | params_missing | aux_fail | enc52_fault | sig_a_err | sig_b_err
                   | sig_n_err | param_error;

  // Program memory test is absent here, so it never causes a request
  assign src_now = {sig_n_err, sig_b_err, sig_a_err, hw_lost, ram_test_fail, wdog_expired,
                    param_error, params_missing, enc52_fault, aux_fail};
  assign src_changed = (src_now != src_prev);

  fdr_record u_record (
    .aux_fail(aux_fail),
    .enc52_fault(enc52_fault),
    .no_config(params_missing),
    .param_error(param_error),
    .wdog_expired(wdog_expired),
    .ram_fail(ram_test_fail),
    .hw_lost(hw_lost),
    .sig_a_err(sig_a_err),
    .sig_b_err(sig_b_err),
    .sig_n_err(sig_n_err),
    .sum_b0(sum_b0),
    .rec_b2(rec_b2),
    .rec_b3(rec_b3),
    .rec_b7(rec_b7),
    .rec_b8(rec_b8)
  );

  // Lamp follows the fault level with no acknowledge needed
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      group_fault_led <= 1'b0;
    end else begin
      group_fault_led <= fault_any;
    end
  end

  // Configuration enables; both come up off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      diag_en <= 1'b0;
      hw_en <= 1'b0;
    end else begin
      diag_en <= diag_irq_enable;
      hw_en <= hw_irq_enable;
    end
  end

  // Hardware interrupt: a repeat before the acknowledge is reported lost
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hw_irq_req <= 1'b0;
    end else if (hw_event && hw_en) begin
      hw_irq_req <= 1'b1;
    end else if (hw_irq_ack) begin
      hw_irq_req <= 1'b0;
    end
  end

  // Lost flag: an acknowledge in the same cycle as a repeat wins and clears it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hw_lost <= 1'b0;
    end else if (hw_event && hw_en && hw_irq_req && !hw_irq_ack) begin
      hw_lost <= 1'b1;
    end else if (hw_irq_ack) begin
      hw_lost <= 1'b0;
    end
  end

  // Source history for edge detection, both incoming and outgoing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      src_prev <= '0;
    end else begin
      src_prev <= src_now;
    end
  end

  // A change seen while a request is pending is kept for one more report
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      redo <= 1'b0;
    end else if (state != st_idle && src_changed) begin
      redo <= 1'b1;
    end else if (state == st_idle) begin
      redo <= 1'b0;
    end
  end

  // Report sequence: latch records first, then raise the request
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (diag_en && (src_changed || redo)) begin
          next_state = st_latch;
        end
      end
      st_latch: begin
        next_state = st_signal;
      end
      st_signal: begin
        if (diag_irq_ack) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Request is a single held level; no second one until acknowledged
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      diag_irq_req <= 1'b0;
    end else begin
      diag_irq_req <= (next_state == st_signal);
    end
  end

  // Detail record snapshot; refreshed whenever sources move and no report is in flight
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `FDR_REC_LEN; i++) begin
        detail[i] <= `FDR_BYTE_RST;
      end
    end else if (state == st_latch || (state == st_idle && !diag_en)) begin
      for (int i = 0; i < `FDR_REC_LEN; i++) begin
        detail[i] <= record_byte(i, sum_b0, rec_b2, rec_b3, rec_b7, rec_b8);
      end
    end
  end

  // Start information carries the summary bytes taken in the same snapshot
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      start_info <= `FDR_INFO_RST;
    end else if (state == st_latch || (state == st_idle && !diag_en)) begin
      start_info <= {rec_b3, rec_b2, `FDR_B1_FIXED, sum_b0};
    end
  end

  // Record read port; index 0 is the summary byte 0 register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rec_rd_data <= `FDR_BYTE_RST;
    end else begin
      rec_rd_data <= detail[rec_rd_idx];
    end
  end

  // Counting is never gated by the diagnostic logic
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_value <= '0;
    end else if (count_pulse) begin
      count_value <= count_value + 1'b1;
    end
  end

  a_led_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    fault_any |=> group_fault_led)
    else $error("fault lamp did not light");

  a_led_dark: assert property (@(posedge core_clk) disable iff (!nrst)
    !fault_any ##1 !fault_any |-> !group_fault_led)
    else $error("fault lamp stayed lit");

  a_req_order: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(diag_irq_req) |-> $past(state == st_latch) && group_fault_led == $past(fault_any))
    else $error("request raised before records");

  a_req_enabled: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(diag_irq_req) |-> $past(diag_en, 2))
    else $error("request without enable");

  a_req_held: assert property (@(posedge core_clk) disable iff (!nrst)
    diag_irq_req && !diag_irq_ack |=> diag_irq_req && $stable(start_info))
    else $error("pending request dropped");

  a_sum_bits: assert property (@(posedge core_clk) disable iff (!nrst)
    start_info[7:1] != 7'h00 |-> start_info[0] && !start_info[5])
    else $error("summary byte 0 inconsistent");

  a_hw_lost: assert property (@(posedge core_clk) disable iff (!nrst)
    hw_event && hw_en && hw_irq_req && !hw_irq_ack |=> hw_lost ##1 1'b1)
    else $error("lost hardware interrupt not flagged");

  a_count_run: assert property (@(posedge core_clk) disable iff (!nrst)
    count_pulse |=> count_value == $past(count_value) + 1'b1)
    else $error("count stalled");

  a_rec_head: assert property (@(posedge core_clk) disable iff (!nrst)
    rec_rd_idx == 4'h1 && state == st_idle |=> rec_rd_data == start_info[15:8])
    else $error("detail head differs from summary");

  a_chan_b8: assert property (@(posedge core_clk) disable iff (!nrst)
    state == st_latch |=> detail[8][3] == 1'b0 && detail[7][0] == start_info[3])
    else $error("detail byte 8 layout wrong");

  a_irq_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !diag_en && state == st_idle |=> !diag_irq_req)
    else $error("request while interrupts disabled");

  a_lost_lamp: assert property (@(posedge core_clk) disable iff (!nrst)
    hw_lost |=> group_fault_led)
    else $error("lost interrupt did not light lamp");
endmodule // fdr_reporter

// ==== rtl/fdr_sync.sv ====
// Three-stage input synchroniser; a change is taken once stages two and three agree
module fdr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage one feeds only stage two to keep metastability contained
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Agreement filter drops single-cycle glitches
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level_out[i] <= stage3[i];
        end
      end
    end
  end
endmodule // fdr_sync
